/* shared/bbt_pkg.sv */
// Package for the detach timer block: register map, resets, timing, states.
// Assumes a 40 MHz core clock and a 32-bit AXI4-Lite register slave.
package bbt_pkg;

    // Clock and timing
    localparam int unsigned CLK_MHZ         = 40;
    localparam int unsigned TICK_TIME_US    = 10000;
    localparam int unsigned TICK_CYCLES     = TICK_TIME_US * CLK_MHZ;

    // Bus geometry
    localparam int unsigned ADDR_W          = 18;
    localparam int unsigned DATA_W          = 32;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_TMO_LOW     = 16'h413E;
    localparam logic [15:0] IDX_TMO_HIGH    = 16'h413F;
    localparam logic [15:0] IDX_CTRL        = 16'h4140;
    localparam logic [15:0] IDX_STATUS      = 16'h4141;
    localparam logic [15:0] IDX_ELAPSED     = 16'h4142;
    localparam logic [15:0] IDX_DESC_BASE   = 16'h4150;

    // Reset values
    localparam logic [15:0] TMO_RESET       = 16'h07D0;
    localparam logic [1:0]  CTRL_RESET      = 2'h1;

    // Control fields
    localparam int unsigned CTRL_EN_BIT     = 0;
    localparam int unsigned CTRL_CANCEL_BIT = 1;

    // Status fields
    localparam int unsigned STAT_STATE_LSB  = 0;
    localparam int unsigned STAT_RUN_BIT    = 2;
    localparam int unsigned STAT_DONE_BIT   = 3;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Descriptor store: words of four descriptor bytes, offset 0 in the low byte
    localparam int unsigned DESC_WORDS      = 12;
    localparam int unsigned DESC_IDX_W      = 4;
    localparam logic [31:0] DESC_W0_RESET   = 32'h0100_0000;
    localparam logic [31:0] DESC_W1_RESET   = 32'h8000_0001;
    localparam logic [31:0] DESC_CFG_RESET  = 32'h0000_0000;
    localparam logic [31:0] DESC_W10_RESET  = 32'h0000_0110;
    localparam logic [31:0] DESC_W11_RESET  = 32'h0000_FF00;
    localparam int unsigned DESC_CFG_FIRST  = 2;
    localparam int unsigned DESC_CFG_LAST   = 9;

    // Register select codes
    typedef enum logic [2:0] {
        SEL_NONE  = 3'h0,
        SEL_LOW   = 3'h1,
        SEL_HIGH  = 3'h2,
        SEL_CTRL  = 3'h3,
        SEL_STAT  = 3'h4,
        SEL_ELAP  = 3'h5,
        SEL_DESC  = 3'h6
    } bbt_sel_e;

    // Timer states, Gray along idle, run, detach, reattach
    typedef enum logic [1:0] {
        ST_IDLE     = 2'h0,
        ST_RUN      = 2'h1,
        ST_DETACH   = 2'h3,
        ST_REATTACH = 2'h2
    } bbt_state_e;

endpackage

/* rtl/bbt_tick_gen.sv */
// Tick generator: one-cycle pulse every TICK_CYCLES clocks.
// Assumes a synchronous active-low reset; restart realigns the period.
`timescale 1ns/1ps
module bbt_tick_gen #(
    parameter int unsigned TICK_CYCLES = 400000
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control
    input  wire logic restart,
    output logic      tick
);
    localparam int unsigned CNT_W = $clog2(TICK_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

    logic [CNT_W-1:0] cnt_r;

    // Restart clears the prescaler so the first unit is a full one
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            cnt_r <= '0;
        end else if (cnt_r == LAST) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            tick <= 1'b0;
        end else begin
            tick <= (cnt_r == LAST);
        end
    end
endmodule

/* rtl/bbt_desc_store.sv */
// Descriptor store: billboard capability bytes held in flip-flops.
// Assumes one write port with byte strobes and two registered read ports.
`timescale 1ns/1ps
module bbt_desc_store
    import bbt_pkg::*;
#(
    parameter int unsigned WORDS = DESC_WORDS
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Software port
    input  wire logic                  wr_en,
    input  wire logic [DESC_IDX_W-1:0] wr_idx,
    input  wire logic [3:0]            wr_strb,
    input  wire logic [31:0]           wr_data,
    input  wire logic [DESC_IDX_W-1:0] sw_idx,
    output logic      [31:0]           sw_data,
    // Function port
    input  wire logic [DESC_IDX_W-1:0] fn_idx,
    output logic      [31:0]           fn_data
);
    logic [31:0] mem_r [WORDS];

    function automatic logic [31:0] word_default(input int unsigned i);
        if (i == 0) return DESC_W0_RESET;
        if (i == 1) return DESC_W1_RESET;
        if (i == 10) return DESC_W10_RESET;
        if (i == 11) return DESC_W11_RESET;
        return DESC_CFG_RESET; // Configured-state words: unspecified error
    endfunction

    function automatic logic [31:0] read_word(input logic [DESC_IDX_W-1:0] idx,
                                              input logic [31:0] w);
        return (32'(idx) < WORDS) ? w : 32'h0000_0000;
    endfunction

    // Byte-writable words let the descriptors be tailored
    for (genvar g = 0; g < WORDS; g++) begin : g_word
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mem_r[g] <= word_default(g);
            end else if (wr_en && (32'(wr_idx) == g)) begin
                for (int b = 0; b < 4; b++) begin
                    if (wr_strb[b]) begin
                        mem_r[g][8*b +: 8] <= wr_data[8*b +: 8];
                    end
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_data <= 32'h0000_0000;
            fn_data <= 32'h0000_0000;
        end else begin
            sw_data <= read_word(sw_idx, mem_r[sw_idx]);
            fn_data <= read_word(fn_idx, mem_r[fn_idx]);
        end
    end
endmodule

/* rtl/bbt_top.sv */
// Detach timer B with its register file and descriptor store.
// Assumes an AXI4-Lite master and a core that pulses alt_str_req per string request.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bbt_top
    import bbt_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0]     s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]          s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Billboard function side
    input  wire logic                  alt_str_req,
    input  wire logic [DESC_IDX_W-1:0] desc_rd_idx,
    output logic      [31:0]           desc_rd_data,
    output logic                       fn_detach,
    output logic                       fn_attach_default,
    output logic                       timer_expired
);
    // Decoding shared by the write and read paths
    function automatic bbt_sel_e reg_sel(input logic [ADDR_W-1:0] addr);
        logic [15:0] idx;
        idx = addr[17:2];
        if (addr[1:0] != 2'h0) return SEL_NONE;
        if (idx == IDX_TMO_LOW) return SEL_LOW;
        if (idx == IDX_TMO_HIGH) return SEL_HIGH;
        if (idx == IDX_CTRL) return SEL_CTRL;
        if (idx == IDX_STATUS) return SEL_STAT;
        if (idx == IDX_ELAPSED) return SEL_ELAP;
        if (idx >= IDX_DESC_BASE && idx < IDX_DESC_BASE + 16'(DESC_WORDS)) return SEL_DESC;
        return SEL_NONE;
    endfunction

    function automatic logic [DESC_IDX_W-1:0] desc_idx(input logic [ADDR_W-1:0] addr);
        logic [15:0] off;
        off = addr[17:2] - IDX_DESC_BASE;
        return off[DESC_IDX_W-1:0];
    endfunction

    // Write channel holding registers
    logic              aw_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic              w_held_r;
    logic [DATA_W-1:0] w_data_r;
    logic [3:0]        w_strb_r;
    logic              wr_go;
    bbt_sel_e          wr_sel;

    // Read channel
    logic              rd_pend_r;
    bbt_sel_e          rd_sel_r;
    logic [DATA_W-1:0] rd_data;

    // Registers and timer
    logic [7:0]        tmo_low_r;
    logic [7:0]        tmo_high_r;
    logic              ctrl_en_r;
    logic              expired_seen_r;
    logic [15:0]       elapsed_r;
    logic [15:0]       elapsed_nxt;
    bbt_state_e        state_r;
    logic              tick;
    logic              start;
    logic              cancel;
    logic [31:0]       desc_sw_data;

    assign wr_go  = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_sel = reg_sel(aw_addr_r);
    assign cancel = wr_go && (wr_sel == SEL_CTRL) && w_strb_r[0] && w_data_r[CTRL_CANCEL_BIT];
    // A request arms the timer only while billboard support is on
    assign start  = alt_str_req && ctrl_en_r && (state_r == ST_IDLE || state_r == ST_RUN);
    assign elapsed_nxt = elapsed_r + 16'h0001;

    // Address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !wr_go;
            s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !wr_go;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Timeout bytes; only lane 0 carries the byte, upper bits read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmo_low_r <= TMO_RESET[7:0];
        end else if (wr_go && wr_sel == SEL_LOW && w_strb_r[0]) begin
            tmo_low_r <= w_data_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmo_high_r <= TMO_RESET[15:8];
        end else if (wr_go && wr_sel == SEL_HIGH && w_strb_r[0]) begin
            tmo_high_r <= w_data_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_en_r <= CTRL_RESET[CTRL_EN_BIT];
        end else if (wr_go && wr_sel == SEL_CTRL && w_strb_r[0]) begin
            ctrl_en_r <= w_data_r[CTRL_EN_BIT];
        end
    end

    // Read path: one request at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !rd_pend_r && !(s_axi_arvalid && s_axi_arready) && !s_axi_rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend_r <= 1'b0;
            rd_sel_r  <= SEL_NONE;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_pend_r <= 1'b1;
            rd_sel_r  <= reg_sel(s_axi_araddr);
        end else begin
            rd_pend_r <= 1'b0;
        end
    end

    always_comb begin
        rd_data = '0;
        case (rd_sel_r)
            SEL_LOW:  rd_data = {24'h00_0000, tmo_low_r};
            SEL_HIGH: rd_data = {24'h00_0000, tmo_high_r};
            SEL_CTRL: rd_data = {31'h0000_0000, ctrl_en_r};
            SEL_STAT: rd_data = {28'h000_0000, expired_seen_r, state_r == ST_RUN, state_r};
            SEL_ELAP: rd_data = {16'h0000, elapsed_r};
            SEL_DESC: rd_data = desc_sw_data;
            default:  rd_data = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_pend_r) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= (rd_sel_r == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Descriptor store; the word is fetched as the read address is taken
    bbt_desc_store #(
        .WORDS   (DESC_WORDS)
    ) u_desc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_go && wr_sel == SEL_DESC),
        .wr_idx  (desc_idx(aw_addr_r)),
        .wr_strb (w_strb_r),
        .wr_data (w_data_r),
        .sw_idx  (desc_idx(s_axi_araddr)),
        .sw_data (desc_sw_data),
        .fn_idx  (desc_rd_idx),
        .fn_data (desc_rd_data)
    );

    // Ten millisecond time base
    bbt_tick_gen #(
        .TICK_CYCLES (TICK_LEN)
    ) u_tick (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .restart     (start || state_r == ST_IDLE),
        .tick        (tick)
    );

    // Elapsed units; a fresh request restarts from zero
    always_ff @(posedge aclk) begin
        if (!aresetn || start) begin
            elapsed_r <= 16'h0000;
        end else if (state_r == ST_RUN && tick) begin
            elapsed_r <= elapsed_nxt;
        end
    end

    // Timer sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (cancel || !ctrl_en_r) begin
                        state_r <= ST_IDLE;
                    end else if (start) begin
                        state_r <= ST_RUN;
                    end else if (tick && elapsed_nxt >= {tmo_high_r, tmo_low_r}) begin
                        state_r <= ST_DETACH;
                    end
                end
                ST_DETACH: begin
                    // Detach is held for one unit so the host sees a real disconnect
                    if (tick) begin
                        state_r <= ST_REATTACH;
                    end
                end
                ST_REATTACH: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Function-side outputs, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_expired <= 1'b0;
        end else begin
            timer_expired <= state_r == ST_RUN && !cancel && ctrl_en_r && !start && tick
                             && elapsed_nxt >= {tmo_high_r, tmo_low_r};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fn_detach         <= 1'b0;
            fn_attach_default <= 1'b0;
        end else begin
            fn_detach         <= (state_r == ST_DETACH);
            fn_attach_default <= (state_r == ST_REATTACH);
        end
    end

    // Sticky expiry flag, cleared by a cancel write; a new expiry wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            expired_seen_r <= 1'b0;
        end else if (timer_expired) begin
            expired_seen_r <= 1'b1;
        end else if (cancel) begin
            expired_seen_r <= 1'b0;
        end
    end

    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot};
endmodule

/* test/bbt_checker.sv */
// Concurrent checks on the detach timer block ports.
// Assumes binding into bbt_top; one clock with a synchronous active-low reset.
`timescale 1ns/1ps
module bbt_checker
    import bbt_pkg::*;
#(
    parameter int unsigned TICK_LEN = 8
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Register bus
    input  wire logic              s_axi_awvalid,
    input  wire logic              s_axi_awready,
    input  wire logic              s_axi_wvalid,
    input  wire logic              s_axi_wready,
    input  wire logic [1:0]        s_axi_bresp,
    input  wire logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    input  wire logic              s_axi_arready,
    input  wire logic [DATA_W-1:0] s_axi_rdata,
    input  wire logic [1:0]        s_axi_rresp,
    input  wire logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Function side
    input  wire logic              fn_detach,
    input  wire logic              fn_attach_default,
    input  wire logic              timer_expired
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Cycles of forced detach so far
    logic [31:0] det_cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || !fn_detach) begin
            det_cnt_r <= 32'h0;
        end else begin
            det_cnt_r <= det_cnt_r + 32'h1;
        end
    end

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence bad_rd_taken;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr[1:0] != 2'h0);
    endsequence

    a_expire_then_detach: assert property (timer_expired |=> fn_detach)
        else $error("detach did not follow expiry");
    a_expire_single: assert property (timer_expired |=> !timer_expired)
        else $error("expiry pulse too long");
    a_detach_length: assert property (fn_detach |-> det_cnt_r < TICK_LEN)
        else $error("detach too long");
    a_attach_after_detach: assert property (fn_attach_default |->
        !fn_detach && ($past(fn_detach) || $past(fn_detach, 2)))
        else $error("reattach without detach");
    a_attach_single: assert property (fn_attach_default |=> !fn_attach_default)
        else $error("reattach pulse too long");
    a_write_answered: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped early");
    a_bad_read_err: assert property (bad_rd_taken |->
        ##[1:3] (s_axi_rvalid && s_axi_rresp == RESP_SLVERR))
        else $error("unaligned read not refused");
    a_reset_quiet: assert property ($rose(aresetn) |->
        !timer_expired && !fn_detach && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active out of reset");
endmodule

bind bbt_top bbt_checker #(.TICK_LEN(TICK_LEN)) bbt_checker_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .fn_detach(fn_detach), .fn_attach_default(fn_attach_default),
    .timer_expired(timer_expired)
);

/* test/bbt_host_model.sv */
// Host-side model: raises the alternate-mode string request and fetches
// descriptor words over the function port. Assumes the bench calls its tasks.
`timescale 1ns/1ps
module bbt_host_model
    import bbt_pkg::*;
(
    // Clock
    input  wire logic                  aclk,
    // Function port
    output logic                       alt_str_req,
    output logic      [DESC_IDX_W-1:0] desc_rd_idx,
    input  wire logic [31:0]           desc_rd_data
);
    initial begin
        alt_str_req = 1'b0;
        desc_rd_idx = '0;
    end

    task automatic request();
        @(posedge aclk);
        alt_str_req <= 1'b1;
        @(posedge aclk);
        alt_str_req <= 1'b0;
    endtask

    // Index is scrambled afterwards so stale data cannot pass
    task automatic read_desc(input logic [DESC_IDX_W-1:0] i, output logic [31:0] d);
        @(posedge aclk);
        desc_rd_idx <= i;
        @(posedge aclk);
        @(posedge aclk);
        d = desc_rd_data;
        desc_rd_idx <= ~i;
    endtask
endmodule

/* test/tb_bbt_top.sv */
// Self-checking bench for the detach timer: register bus tasks and timer runs.
// Assumes a shortened tick period; all waits are bounded.
`timescale 1ns/1ps
module tb_bbt_top;
    import bbt_pkg::*;
    localparam int          TL     = 8;
    localparam logic [17:0] A_LOW  = {IDX_TMO_LOW, 2'h0};
    localparam logic [17:0] A_HIGH = {IDX_TMO_HIGH, 2'h0};
    localparam logic [17:0] A_CTRL = {IDX_CTRL, 2'h0};
    localparam logic [17:0] A_STAT = {IDX_STATUS, 2'h0};
    localparam logic [17:0] A_DESC = {IDX_DESC_BASE, 2'h0};
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [17:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d_data, d;
    logic [3:0]  wstrb = 4'hF, d_idx;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, alt_req, detach, attach, expired;
    logic [1:0]  bresp, rresp;
    int          errors = 0, num_checks = 0, i, n;

    always #12.5 aclk = ~aclk;

    bbt_top #(.TICK_LEN(TL)) bbt_top_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .alt_str_req(alt_req), .desc_rd_idx(d_idx),
        .desc_rd_data(d_data), .fn_detach(detach), .fn_attach_default(attach),
        .timer_expired(expired)
    );
    bbt_host_model bbt_host_model_i (
        .aclk(aclk), .alt_str_req(alt_req), .desc_rd_idx(d_idx), .desc_rd_data(d_data)
    );

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic hang(input string nm);
        check(nm, 32'h0, 32'h1);
        end_of_test();
    endtask
    task automatic wr_chk(input logic [17:0] a, input logic [31:0] v, input logic [1:0] er);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (k == 64) hang("bvalid");
        check("bresp", bresp, er);
        bready <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [17:0] a, input logic [31:0] ed,
                          input logic [1:0] er, input logic [31:0] m = 32'hFFFF_FFFF);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (k == 64) hang("rvalid");
        check(nm, rdata & m, ed);
        check("rresp", rresp, er);
        rready <= 1'b0;
    endtask
    task automatic wait_exp(input int lim, output int c);
        c = 0;
        while (c < lim && expired !== 1'b1) begin
            @(posedge aclk);
            c++;
        end
    endtask
    // One full timeout, then status and its clear
    task automatic run_exp(input int t);
        int c;
        bbt_host_model_i.request();
        wait_exp(t * TL + 8, c);
        if (c == t * TL + 8) hang("expiry");
        check("expiry_time", 32'(c >= t*TL - 2 && c <= t*TL + 4), 32'h1);
        @(posedge aclk);
        check("detach", 32'(detach), 32'h1);
        for (c = 0; c < 2 * TL + 8 && attach !== 1'b1; c++) @(posedge aclk);
        check("attach_time", 32'(c >= TL - 2 && c <= TL + 4), 32'h1);
        rd_chk("status", A_STAT, 32'h8, RESP_OKAY, 32'hF);
        wr_chk(A_CTRL, 32'h3, RESP_OKAY);
        rd_chk("status_clr", A_STAT, 32'h0, RESP_OKAY, 32'hF);
    endtask
    localparam logic [31:0] DESC_EXP [12] = '{32'h0100_0000, 32'h8000_0001, '0, '0, '0, '0,
        '0, '0, '0, '0, 32'h0000_0110, 32'h0000_FF00};

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk("tmo_low", A_LOW, 32'hD0, RESP_OKAY);
        rd_chk("tmo_high", A_HIGH, 32'h07, RESP_OKAY);
        for (i = 0; i < 12; i++) begin
            rd_chk("desc_word", A_DESC + 18'(4 * i), DESC_EXP[i], RESP_OKAY);
            bbt_host_model_i.read_desc(4'(i), d);
            check("desc_fn", d, DESC_EXP[i]);
        end
        wr_chk(A_HIGH, 32'hA5, RESP_OKAY);
        rd_chk("tmo_high_rw", A_HIGH, 32'hA5, RESP_OKAY);
        wr_chk(A_LOW, 32'h5A, RESP_OKAY);
        rd_chk("tmo_low_rw", A_LOW, 32'h5A, RESP_OKAY);
        wr_chk(18'h00010, 32'h1, RESP_SLVERR);
        rd_chk("unmapped", 18'h00010, 32'h0, RESP_SLVERR);
        rd_chk("unaligned", A_LOW + 18'h1, 32'h0, RESP_SLVERR);
        wr_chk(A_DESC, 32'h1234_5678, RESP_OKAY);
        bbt_host_model_i.read_desc(4'h0, d);
        check("desc_custom", d, 32'h1234_5678);
        wr_chk(A_LOW, 32'h3, RESP_OKAY);
        wr_chk(A_HIGH, 32'h0, RESP_OKAY);
        run_exp(3);
        // A second request restarts the count
        bbt_host_model_i.request();
        repeat (2 * TL) @(posedge aclk);
        rd_chk("status_run", A_STAT, 32'h5, RESP_OKAY, 32'hF);
        run_exp(3);
        wr_chk(A_LOW, 32'h0, RESP_OKAY);
        wr_chk(A_HIGH, 32'h1, RESP_OKAY);
        run_exp(256);
        wr_chk(A_HIGH, 32'h0, RESP_OKAY);
        wr_chk(A_LOW, 32'h3, RESP_OKAY);
        wr_chk(A_CTRL, 32'h0, RESP_OKAY);
        bbt_host_model_i.request();
        wait_exp(6 * TL, n);
        check("no_expiry_disabled", n, 6 * TL);
        wr_chk(A_CTRL, 32'h1, RESP_OKAY);
        end_of_test();
    end
endmodule
